// [hdl/srs_params.svh]
// constants for the latch set-source selection block
// assumes inclusion by bare name from the divider and set-select design files
`ifndef SRS_PARAMS_SVH
`define SRS_PARAMS_SVH
`define SRS_ADDR_CTRL0 12'h000
`define SRS_ADDR_ENABLES 12'h004
`define SRS_ADDR_STATUS 12'h008
`define SRS_RESET_BYTE 8'h00
`define SRS_BIT_PIN_SET 7
`define SRS_BIT_CLK_SET 6
`define SRS_BIT_CMP2_SET 5
`define SRS_BIT_CMP1_SET 4
`define SRS_BIT_PULSE_SET 1
`define SRS_DIV_LSB 4
`define SRS_DIV_MSB 6
`define SRS_DIV_MIN_LOG2 9'h002
`define SRS_CNT_W 9
`define SRS_CNT_ZERO 9'h000
`define SRS_CNT_ONE 9'h001
`endif

// [hdl/srs_pkg.sv]
// types shared by the latch set-source selection design
// assumes nothing beyond a SystemVerilog compiler
package srs_pkg;
   typedef logic [7:0] srs_byte_t;
   typedef logic [2:0] srs_div_sel_t;
   typedef enum logic [1:0] {
      SRS_IDLE = 2'b00,
      SRS_ACCESS = 2'b01
   } srs_apb_state_t;
endpackage

// [hdl/srs_div_if.sv]
// carrier between register block and divided-pulse generator
// assumes one clock domain, mclk
`timescale 1ns/100ps
interface srs_div_if;
   logic [2:0] div_sel;
   logic pulse;
   modport ctrl (output div_sel, input pulse);
   modport gen (input div_sel, output pulse);
endinterface

// [hdl/srs_divider.sv]
// divided-pulse source: one cycle wide pulse every 4..512 cycles
// assumes mclk free running, div_sel static or changed by software
`timescale 1ns/100ps
`include "srs_params.svh"
module srs_divider
   import srs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   srs_div_if.gen div
);
   logic [`SRS_CNT_W-1:0] count;
   logic [`SRS_CNT_W-1:0] period_m1;
   logic at_end;
   logic [`SRS_CNT_W-1:0] next_count;
   // period = 2^(sel+2); a code change takes effect at the next wrap or sooner
   assign period_m1 = (`SRS_CNT_ONE << (`SRS_DIV_MIN_LOG2 + {6'h00, div.div_sel})) - `SRS_CNT_ONE;
   assign at_end = (count >= period_m1);
   assign next_count = at_end ? `SRS_CNT_ZERO : count + `SRS_CNT_ONE;
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         count <= `SRS_CNT_ZERO;
         div.pulse <= 1'b0;
      end else begin
         count <= next_count;
         div.pulse <= at_end;
      end
   end
endmodule

// [hdl/srs_set_select.sv]
// latch set-source selection with APB register access
// assumes APB master on mclk, inputs synchronous to mclk
`timescale 1ns/100ps
`include "srs_params.svh"
module srs_set_select
   import srs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic latch_external_input_pin,
   input wire logic comparator_one,
   input wire logic comparator_two,
   output logic latch_set,
   output logic divided_pulse_source
);

   srs_div_if div_bus();

   // register state
   srs_byte_t ctrl0;
   srs_byte_t sr_latch_source_enables;
   srs_apb_state_t state;
   srs_apb_state_t next_state;
   logic pulse_req;

   // bus decode
   logic sel_ctrl0;
   logic sel_en;
   logic sel_stat;
   logic mapped;
   logic setup;
   logic rd_setup;
   logic done;
   logic wr;
   logic wr_ctrl0;
   logic wr_en;

   // set sources
   logic pin_set_enable;
   logic clock_set_enable;
   logic cmp_two_set_enable;
   logic cmp_one_set_enable;
   logic pin_term;
   logic clk_term;
   logic cmp2_term;
   logic cmp1_term;

   // read path and next values
   logic [7:0] status_byte;
   logic [7:0] ctrl0_read;
   logic [7:0] read_byte;
   logic next_latch_set;
   logic next_divided_pulse_source;
   logic next_pready;
   logic next_pslverr;
   logic [31:0] next_prdata;
   srs_byte_t next_ctrl0;
   srs_byte_t next_enables;
   logic next_pulse_req;

   // one compare serves the read mux, the write strobes and the error flag
   function automatic logic srs_hit(
      input logic [11:0] addr,
      input logic [11:0] offset
   );
      return (addr == offset);
   endfunction

   assign sel_ctrl0 = srs_hit(paddr, `SRS_ADDR_CTRL0);
   assign sel_en = srs_hit(paddr, `SRS_ADDR_ENABLES);
   assign sel_stat = srs_hit(paddr, `SRS_ADDR_STATUS);
   assign mapped = sel_ctrl0 | sel_en | sel_stat;

   assign setup = psel & ~penable;
   assign rd_setup = setup & ~pwrite;
   // answer one cycle after setup: access phase always has pready high
   assign done = psel & penable & (state == SRS_ACCESS);
   assign wr = done & pwrite & mapped;
   assign wr_ctrl0 = wr & sel_ctrl0;
   assign wr_en = wr & sel_en;

   assign pin_set_enable = sr_latch_source_enables[`SRS_BIT_PIN_SET];
   assign clock_set_enable = sr_latch_source_enables[`SRS_BIT_CLK_SET];
   assign cmp_two_set_enable = sr_latch_source_enables[`SRS_BIT_CMP2_SET];
   assign cmp_one_set_enable = sr_latch_source_enables[`SRS_BIT_CMP1_SET];

   assign pin_term = pin_set_enable & latch_external_input_pin;
   assign clk_term = clock_set_enable & div_bus.pulse;
   assign cmp2_term = cmp_two_set_enable & comparator_two;
   assign cmp1_term = cmp_one_set_enable & comparator_one;
   // no reset-side sources here, so same-source conflict is left to software
   assign next_latch_set = pin_term | clk_term | cmp2_term | cmp1_term | pulse_req;
   // observation copy, one cycle behind the internal pulse like the set path
   assign next_divided_pulse_source = div_bus.pulse;

   assign status_byte = {4'h0, latch_set, div_bus.pulse, comparator_two, comparator_one};
   // pulse-set bit is write-only and reads back zero
   assign ctrl0_read = ctrl0 & ~(8'h01 << `SRS_BIT_PULSE_SET);
   assign read_byte = sel_ctrl0 ? ctrl0_read : sel_en ? sr_latch_source_enables :
                      sel_stat ? status_byte : 8'h00;

   assign next_pready = setup & (state == SRS_IDLE);
   assign next_pslverr = setup & ~mapped;
   // read data is latched at setup so it stands through the access cycle
   assign next_prdata = rd_setup ? {24'h00_0000, read_byte} : prdata;
   assign next_ctrl0 = wr_ctrl0 ? pwdata[7:0] : ctrl0;
   assign next_enables = wr_en ? pwdata[7:0] : sr_latch_source_enables;
   // software pulse lasts exactly one cycle
   assign next_pulse_req = wr_ctrl0 & pwdata[`SRS_BIT_PULSE_SET];

   assign div_bus.div_sel = ctrl0[`SRS_DIV_MSB:`SRS_DIV_LSB];

   // setup is taken only from idle, so a stuck penable cannot commit twice
   always_comb begin
      next_state = state;
      unique case (state)
         SRS_IDLE: if (setup) next_state = SRS_ACCESS;
         SRS_ACCESS: next_state = SRS_IDLE;
         // unused codes fall back to idle rather than lock the bus
         default: next_state = SRS_IDLE;
      endcase
   end

   // one flop per block keeps each reset value beside its register
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state <= SRS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pready <= 1'b0;
      end else begin
         pready <= next_pready;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= next_prdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= next_pslverr;
      end
   end

   // bit 0 is kept for the reset side, which lies outside this block
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ctrl0 <= `SRS_RESET_BYTE;
      end else begin
         ctrl0 <= next_ctrl0;
      end
   end

   // low nibble holds the reset-side enables, stored but unused here
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         sr_latch_source_enables <= `SRS_RESET_BYTE;
      end else begin
         sr_latch_source_enables <= next_enables;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pulse_req <= 1'b0;
      end else begin
         pulse_req <= next_pulse_req;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         latch_set <= 1'b0;
      end else begin
         latch_set <= next_latch_set;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         divided_pulse_source <= 1'b0;
      end else begin
         divided_pulse_source <= next_divided_pulse_source;
      end
   end

   // divider runs from reset whatever the enables, so its phase is known
   srs_divider u_div (
      .mclk(mclk),
      .rst_b(rst_b),
      .div(div_bus.gen)
   );
endmodule

// [verification/srs_set_select_asserts.sv]
// checker for the set-source block, ports only
// assumes a bind onto srs_set_select
`timescale 1ns/100ps
module srs_set_select_asserts (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic latch_external_input_pin,
   input wire logic comparator_one,
   input wire logic comparator_two,
   input wire logic latch_set,
   input wire logic divided_pulse_source
);
   logic [3:0] en;
   wire acc = psel && penable && pready && pwrite;
   wire pls = acc && paddr == 12'h000 && pwdata[1];
   wire src = latch_external_input_pin && en[3] || comparator_two && en[1] || comparator_one && en[0];
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // shadow of the enables, since the register is not a port
   always_ff @(posedge mclk) begin
      if (!rst_b) en <= 4'h0;
      else if (acc && paddr == 12'h004) en <= pwdata[7:4];
   end
   AST_PIN: assert property (latch_external_input_pin && en[3] |=> latch_set) else $error("pin set lost");
   AST_CMP2: assert property (comparator_two && en[1] |=> latch_set) else $error("cmp2 set lost");
   AST_CMP1: assert property (comparator_one && en[0] |=> latch_set) else $error("cmp1 set lost");
   AST_CLK: assert property (divided_pulse_source && $past(en[2]) |-> latch_set) else $error("clk set lost");
   AST_ONLY: assert property (latch_set |->
      $past(src) || divided_pulse_source && $past(en[2]) || $past(pls, 2)) else $error("set without source");
   AST_DIV: assert property (divided_pulse_source |=> !divided_pulse_source [*3]) else $error("pulse too dense");
   AST_RDY: assert property (psel && !penable |=> pready) else $error("no ready");
   AST_ERR: assert property (pslverr |-> pready && paddr != 12'h000 && paddr != 12'h004 && paddr != 12'h008)
      else $error("bad error");
   cover property (divided_pulse_source && latch_set);
   cover property (pslverr);
   cover property ($past(pls, 2) && latch_set);
endmodule

// [verification/testbench.sv]
// self-checking bench for the set-source block
// assumes design files compiled first
`timescale 1ns/100ps
module testbench;
   logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pin = 0, c1 = 0, c2 = 0, er;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, set, dps;
   logic [7:0] msk [3] = '{8'h80, 8'h20, 8'h10};
   int n_fail = 0, compares = 0, k;
   logic [31:0] n, m;
   always #20 mclk = ~mclk;
   srs_set_select srs_set_select_i (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .latch_external_input_pin(pin), .comparator_one(c1), .comparator_two(c2), .latch_set(set),
      .divided_pulse_source(dps));
   task final_report;
      $display("n_fail=%0d compares=%0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic ok, input string s);
      compares++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("[ERR] %0t %s", $time, s);
      end
   endtask
   // holds the request until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge mclk);
      if (k >= 20) begin
         chk(0, "apb hang");
         final_report();
      end
   endtask
   task t_regs;
      apb(1, 12'h00C, 32'hFF);
      chk(er === 1'b1, "unmapped write error");
      apb(0, 12'h004, 0);
      chk(rd === 32'h0 && er === 1'b0, "enables reset");
      apb(0, 12'h00C, 0);
      chk(rd === 32'h0 && er === 1'b1, "unmapped");
   endtask
   task t_src;
      for (int i = 0; i < 3; i++) begin
         apb(1, 12'h004, {24'h0, 8'hB0 ^ msk[i]});
         {c1, c2, pin} <= 3'b001 << i;
         repeat (2) @(posedge mclk);
         chk(set === 1'b0, "disabled source set");
         apb(1, 12'h004, {24'h0, msk[i]});
         repeat (2) @(posedge mclk);
         chk(set === 1'b1, "enabled source idle");
         apb(0, 12'h008, 0);
         chk((rd & 32'hFFFF_FFFB) === {28'h0, 2'b10, c2, c1}, "status bits");
         {c1, c2, pin} <= 3'b000;
      end
   endtask
   task t_clk(input int c, input logic [7:0] e);
      apb(1, 12'h000, c << 4);
      apb(1, 12'h004, {24'h0, e});
      repeat (32) @(posedge mclk);
      n = 0;
      m = 0;
      repeat (128) begin
         @(posedge mclk);
         n += set;
         m += dps;
      end
      chk(m == (128 >> (c + 2)) && n == (e[6] ? m : 0), "clock source count");
   endtask
   task t_pulse;
      apb(1, 12'h000, 32'h2);
      n = 0;
      repeat (6) begin
         @(posedge mclk);
         n += set;
      end
      chk(n == 1, "pulse set width");
      apb(0, 12'h000, 0);
      chk(rd === 32'h0, "pulse bit reads 0");
   endtask
   // long divider codes: measure the gap between two pulses after the first wrap
   task t_period(input int c);
      apb(1, 12'h000, c << 4);
      apb(0, 12'h000, 0);
      chk(rd === (c << 4), "divider code readback");
      k = 0;
      while (dps !== 1'b1 && k < 1100) begin
         @(posedge mclk);
         k++;
      end
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (dps !== 1'b1 && n < 1100);
      chk(n === (32'd4 << c), "divider period");
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      rst_b <= 1;
      @(posedge mclk);
      t_regs();
      t_src();
      for (int c = 0; c < 4; c++) t_clk(c, 8'h40);
      t_clk(1, 8'h00);
      for (int c = 4; c < 8; c++) t_period(c);
      t_pulse();
      final_report();
   end
endmodule
bind srs_set_select srs_set_select_asserts srs_set_select_asserts_i (.mclk, .rst_b, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .pslverr, .latch_external_input_pin, .comparator_one, .comparator_two, .latch_set,
   .divided_pulse_source);
